// ---- verilog/cbt_pkg.sv ----
// package: constants, register layout and carrier types for the can bit-timing block
// Contract
// - wake filter bit set routes bus line through line filter for wake-up
// - phase two field bits 18..16 gives length field plus one quanta
// - free select set uses programmed phase two, else max(phase one, ipt)
// - triple sample bit set samples bus three times, else once
// - phase one field bits 13..11 gives length field plus one quanta
// - phase two not below phase one; hardware sets it when free select clear (with free select set, a shorter programmed phase two is kept)
// - register writes accepted only in configuration mode, code 100
package cbt_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CBT_ADDR_BIT_TIMING = 8'h00;
    localparam logic [7:0] CBT_ADDR_CONTROL = 8'h04;
    localparam logic [7:0] CBT_ADDR_STATUS = 8'h08;
    localparam logic [31:0] CBT_RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] CBT_WRITE_MASK = 32'h0047_FFFF;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CBT_WAKE_BIT = 22;
    localparam int CBT_PH2_LSB = 16;
    localparam int CBT_FREE_BIT = 15;
    localparam int CBT_TRIPLE_BIT = 14;
    localparam int CBT_PH1_LSB = 11;
    localparam int CBT_PROP_LSB = 8;
    localparam int CBT_SJW_LSB = 6;
    localparam int CBT_BRP_LSB = 0;
    localparam int CBT_MODE_LSB = 21;
    // ------------------------------------------------------------
    // modes and timing constants
    // ------------------------------------------------------------
    localparam logic [2:0] CBT_MODE_CONFIG = 3'h4;
    localparam logic [2:0] CBT_MODE_RESET_VALUE = 3'h4;
    localparam logic [3:0] CBT_IPT_QUANTA = 4'h2;
    localparam logic [3:0] CBT_ONE = 4'h1;
    localparam logic [6:0] CBT_ONE7 = 7'h01;
    localparam logic [1:0] CBT_TICK_INIT = 2'h0;

    typedef struct packed {
        logic wake_line_filter_enable;
        logic [2:0] phase_two_length;
        logic phase_two_free_select;
        logic triple_sample_select;
        logic [2:0] phase_one_length;
        logic [2:0] propagation_segment_length;
        logic [1:0] resync_jump_width;
        logic [5:0] baud_prescaler;
    } cbt_cfg_s;

    typedef struct packed {
        logic [3:0] sync_tq;
        logic [3:0] prop_tq;
        logic [3:0] ph1_tq;
        logic [3:0] ph2_tq;
        logic [3:0] sjw_tq;
        logic [6:0] prescale;
        logic [5:0] bit_tq;
        logic triple;
        logic wake_filter;
    } cbt_timing_s;
endpackage : cbt_pkg

// ---- verilog/cbt_sync3.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module cbt_sync3 (
    input wire logic clock,
    input wire logic nrst,
    input wire logic pin,
    output logic level
);
    import cbt_pkg::*;
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic level_reg;
    logic level_next;

    // first stage feeds only the second
    always_comb begin
        stage_next = {stage_reg[1:0], pin};
        level_next = (stage_reg[2] == stage_reg[1]) ? stage_reg[2] : level_reg;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage_reg <= 3'h7;
            level_reg <= 1'b1;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule : cbt_sync3
`default_nettype wire

// ---- verilog/cbt_top.sv ----
// can bit-timing register, apb slave and derived segment timing
`timescale 1ns/100ps
`default_nettype none
module cbt_top
    import cbt_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic can_rx_pin,
    input wire logic [2:0] operating_mode_field,
    input wire logic sample_strobe,
    output logic wake_line,
    output logic bus_sample,
    output cbt_timing_s timing
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [31:0] cfg_reg;
    logic [31:0] cfg_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic reject_reg;
    logic reject_next;
    cbt_timing_s timing_reg;
    cbt_timing_s timing_next;
    cbt_cfg_s cfg;
    logic access;
    logic config_mode;
    logic rx_level;
    logic [2:0] hist_reg;
    logic [2:0] hist_next;
    logic sample_reg;
    logic sample_next;
    logic wake_reg;
    logic wake_next;
    logic [3:0] ph1_q;
    logic [3:0] ph2_q;
    logic [3:0] sjw_q;
    logic [2:0] raw_reg;
    logic [2:0] raw_next;

    cbt_sync3 i_cbt_sync3 (
        .clock(clock),
        .nrst(nrst),
        .pin(can_rx_pin),
        .level(rx_level)
    );

    assign cfg = cbt_cfg_s'({cfg_reg[CBT_WAKE_BIT], cfg_reg[CBT_PH2_LSB +: 3],
        cfg_reg[CBT_FREE_BIT], cfg_reg[CBT_TRIPLE_BIT], cfg_reg[CBT_PH1_LSB +: 3],
        cfg_reg[CBT_PROP_LSB +: 3], cfg_reg[CBT_SJW_LSB +: 2], cfg_reg[CBT_BRP_LSB +: 6]});
    assign access = psel && penable;
    assign config_mode = (operating_mode_field == CBT_MODE_CONFIG);

    // ------------------------------------------------------------
    // apb register access
    // ------------------------------------------------------------
    always_comb begin
        cfg_next = cfg_reg;
        prdata_next = prdata_reg;
        reject_next = reject_reg;
        if (access && pwrite && paddr == CBT_ADDR_BIT_TIMING) begin
            // mode-locked writes are dropped silently, recorded in status
            if (config_mode) begin
                cfg_next = pwdata & CBT_WRITE_MASK;
            end else begin
                reject_next = 1'b1;
            end
        end
        if (access && !pwrite) begin
            case (paddr)
                CBT_ADDR_BIT_TIMING: prdata_next = cfg_reg;
                CBT_ADDR_CONTROL: prdata_next = {8'h00, 1'b0, operating_mode_field,
                    20'h00000};
                CBT_ADDR_STATUS: prdata_next = {26'h0, timing_reg.bit_tq};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        if (access && paddr == CBT_ADDR_STATUS) begin
            prdata_next[31] = reject_reg;
            reject_next = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= CBT_RESET_VALUE;
            prdata_reg <= 32'h0000_0000;
            reject_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            prdata_reg <= prdata_next;
            reject_reg <= reject_next;
        end
    end

    // zero wait states: read data registered in the access cycle would lag,
    // so reads take one wait state and writes none
    logic rd_wait_reg;
    logic rd_wait_next;
    always_comb begin
        rd_wait_next = access && !pwrite && !rd_wait_reg;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_wait_reg <= 1'b0;
        end else begin
            rd_wait_reg <= rd_wait_next;
        end
    end
    assign pready = pwrite ? 1'b1 : rd_wait_reg;
    assign pslverr = 1'b0;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // segment timing derivation
    // ------------------------------------------------------------
    always_comb begin
        ph1_q = {1'b0, cfg.phase_one_length} + CBT_ONE;
        sjw_q = {2'b00, cfg.resync_jump_width} + CBT_ONE;
        if (cfg.phase_two_free_select) begin
            ph2_q = {1'b0, cfg.phase_two_length} + CBT_ONE;
        end else begin
            // hardware picks phase two, never shorter than processing time
            ph2_q = (ph1_q > CBT_IPT_QUANTA) ? ph1_q : CBT_IPT_QUANTA;
        end
        timing_next.sync_tq = CBT_ONE;
        timing_next.prop_tq = {1'b0, cfg.propagation_segment_length} + CBT_ONE;
        timing_next.ph1_tq = ph1_q;
        timing_next.ph2_tq = ph2_q;
        timing_next.sjw_tq = sjw_q;
        timing_next.prescale = {1'b0, cfg.baud_prescaler} + CBT_ONE7;
        timing_next.bit_tq = 6'({2'b00, CBT_ONE} + {2'b00, timing_next.prop_tq}
            + {2'b00, ph1_q} + {2'b00, ph2_q});
        timing_next.triple = cfg.triple_sample_select;
        timing_next.wake_filter = cfg.wake_line_filter_enable;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            timing_reg <= '0;
        end else begin
            timing_reg <= timing_next;
        end
    end
    assign timing = timing_reg;

    // ------------------------------------------------------------
    // bus sampling and wake line
    // ------------------------------------------------------------
    always_comb begin
        hist_next = hist_reg;
        sample_next = sample_reg;
        if (sample_strobe) begin
            hist_next = {hist_reg[1:0], rx_level};
            if (cfg.triple_sample_select) begin
                // majority of this strobe's sample and the two previous strobe samples
                sample_next = (hist_reg[1] & hist_reg[0]) | (hist_reg[1] & rx_level)
                    | (hist_reg[0] & rx_level);
            end else begin
                sample_next = rx_level;
            end
        end
        // filtered wake path uses the agreed level, raw path the plain flop chain
        wake_next = cfg.wake_line_filter_enable ? rx_level : raw_reg[2];
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hist_reg <= 3'h7;
            sample_reg <= 1'b1;
            wake_reg <= 1'b1;
        end else begin
            hist_reg <= hist_next;
            sample_reg <= sample_next;
            wake_reg <= wake_next;
        end
    end
    assign bus_sample = sample_reg;
    assign wake_line = wake_reg;

    // ------------------------------------------------------------
    // unfiltered wake path
    // ------------------------------------------------------------
    // the pin is asynchronous even with the line filter off, so the raw
    // path still passes three flops; it only skips the agreement check
    always_comb begin
        raw_next = {raw_reg[1:0], can_rx_pin};
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            raw_reg <= '1;
        end else begin
            raw_reg <= raw_next;
        end
    end
endmodule : cbt_top
`default_nettype wire

// ---- verification/cbt_asserts.sv ----
// checker: port-level assertions for the bit-timing block
`timescale 1ns/100ps
`default_nettype none
module cbt_asserts
    import cbt_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic can_rx_pin,
    input wire logic [2:0] operating_mode_field,
    input wire logic sample_strobe,
    input wire logic wake_line,
    input wire logic bus_sample,
    input wire cbt_timing_s timing
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic wr_hit;
    logic wr_ok;
    assign wr_hit = psel && penable && pwrite && pready && paddr == CBT_ADDR_BIT_TIMING;
    assign wr_ok = wr_hit && operating_mode_field == CBT_MODE_CONFIG;
    AST_WAKE: assert property (wr_ok |-> ##2 timing.wake_filter == $past(pwdata[22], 2))
        else $error("wake filter flag wrong");
    AST_PH2: assert property (wr_ok && pwdata[15] |-> ##2
        timing.ph2_tq == $past(pwdata[18:16], 2) + 4'h1) else $error("phase two length wrong");
    AST_PH2_AUTO: assert property (wr_ok && !pwdata[15] |-> ##2 timing.ph2_tq ==
        ($past(pwdata[13:11], 2) == 3'h0 ? 4'h2 : $past(pwdata[13:11], 2) + 4'h1))
        else $error("automatic phase two wrong");
    AST_TRIPLE: assert property (wr_ok |-> ##2 timing.triple == $past(pwdata[14], 2))
        else $error("sampling select wrong");
    AST_SAMPLE_HOLD: assert property (!sample_strobe |=> $stable(bus_sample))
        else $error("bus sample moved without strobe");
    AST_PH1: assert property (wr_ok |-> ##2
        timing.ph1_tq == $past(pwdata[13:11], 2) + 4'h1) else $error("phase one length wrong");
    AST_LOCKED: assert property (wr_hit && !wr_ok && !$past(wr_ok) |=> $stable(timing)[*2])
        else $error("timing changed outside configuration mode");
    AST_SJW_BRP: assert property (wr_ok |-> ##2 timing.sjw_tq == $past(pwdata[7:6], 2) + 4'h1
        && timing.prescale == $past(pwdata[5:0], 2) + 7'h01) else $error("jump width or prescale wrong");
    COV_WRITE: cover property (wr_ok);
    COV_REJECT: cover property (wr_hit && !wr_ok);
    COV_TRIPLE: cover property (sample_strobe && timing.triple);
endmodule : cbt_asserts
`default_nettype wire

// ---- verification/cbt_bus_node.sv ----
// bus node model: drives the receive pin and a sample point every eight clocks
`timescale 1ns/100ps
`default_nettype none
module cbt_bus_node (
    input wire logic clock,
    input wire logic nrst,
    input wire logic level,
    output logic can_rx_pin,
    output logic sample_strobe
);
    logic [2:0] cnt_reg;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) cnt_reg <= 3'h0;
        else cnt_reg <= cnt_reg + 3'h1;
    end
    assign sample_strobe = cnt_reg == 3'h7;
    assign can_rx_pin = level;
endmodule : cbt_bus_node
`default_nettype wire

// ---- verification/tb_top.sv ----
// testbench: register access, decoded timing, mode lock and sampling
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import cbt_pkg::*;
;
    logic clock, nrst, psel, penable, pwrite, level, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] operating_mode_field;
    logic can_rx_pin, sample_strobe, wake_line, bus_sample;
    cbt_timing_s timing;
    int errors, checked;
    // words mix single and triple sampling, one sets bits outside the write mask, all over seven quanta
    logic [31:0] words [4] = '{32'h0047_FFFF, 32'hFFBA_9900, 32'h0007_0501, 32'h0000_6842};
    cbt_top i_cbt_top (.*);
    cbt_bus_node i_cbt_bus_node (.*);
    always #25 clock = ~clock;
    task automatic check(input string n, input logic [39:0] s, input logic [39:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        check("pslverr", pslverr, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    function automatic cbt_timing_s exp_t(input logic [31:0] w);
        cbt_timing_s e;
        e.sync_tq = 4'h1;
        e.prop_tq = {1'b0, w[10:8]} + 4'h1;
        e.ph1_tq = {1'b0, w[13:11]} + 4'h1;
        e.ph2_tq = w[15] ? {1'b0, w[18:16]} + 4'h1 : (w[13:11] == 3'h0 ? 4'h2 : e.ph1_tq);
        e.sjw_tq = {2'h0, w[7:6]} + 4'h1;
        e.prescale = {1'b0, w[5:0]} + 7'h01;
        e.bit_tq = {2'h0, e.sync_tq} + {2'h0, e.prop_tq} + {2'h0, e.ph1_tq} + {2'h0, e.ph2_tq};
        e.triple = w[14];
        e.wake_filter = w[22];
        return e;
    endfunction : exp_t
    task automatic t_config();
        foreach (words[i]) begin
            apb(1'b1, 8'h00, words[i]);
            apb(1'b0, 8'h00, 32'h0);
            check("readback", rd, words[i] & 32'h0047_FFFF);
            check("timing", timing, exp_t(words[i]));
        end
    endtask : t_config
    task automatic t_reject();
        cbt_timing_s e;
        for (int m = 0; m < 8; m++) begin
            operating_mode_field <= 3'(m);
            apb(1'b1, CBT_ADDR_BIT_TIMING, 32'h0040_1A00);
            apb(1'b0, CBT_ADDR_BIT_TIMING, 32'h0);
            check("locked", rd, m == 4 ? 32'h0040_1A00 : words[3]);
            apb(1'b0, CBT_ADDR_CONTROL, 32'h0);
            check("mode view", rd, {8'h00, 1'b0, 3'(m), 20'h00000});
            e = exp_t(m == 4 ? 32'h0040_1A00 : words[3]);
            apb(1'b0, CBT_ADDR_STATUS, 32'h0);
            check("status", rd, {m != 4, 25'h0, e.bit_tq});
            if (m == 4) apb(1'b1, CBT_ADDR_BIT_TIMING, words[3]);
        end
        operating_mode_field <= 3'h4;
    endtask : t_reject
    task automatic t_sample();
        level <= 1'b0;
        repeat (40) @(posedge clock);
        check("bus low", bus_sample, 1'b0);
        check("wake low", wake_line, 1'b0);
        level <= 1'b1;
        repeat (40) @(posedge clock);
        check("bus high", bus_sample, 1'b1);
    endtask : t_sample
    // one-strobe low glitch: triple sampling outvotes it, single sampling takes it
    task automatic t_glitch(input logic [31:0] w, input logic e_bus, input logic e_wake);
        apb(1'b1, CBT_ADDR_BIT_TIMING, w);
        repeat (16) @(posedge clock);
        do @(posedge clock); while (sample_strobe !== 1'b1);
        level <= 1'b0;
        repeat (5) @(posedge clock);
        check("wake path", wake_line, e_wake);
        repeat (3) @(posedge clock);
        level <= 1'b1;
        repeat (4) @(posedge clock);
        check("glitch", bus_sample, e_bus);
    endtask : t_glitch
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (6000) @(posedge clock);
        errors++;
        tally_and_finish();
    end
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        level = 1'b1;
        operating_mode_field = 3'h4;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        apb(1'b0, 8'h00, 32'h0);
        check("reset value", rd, 32'h0);
        t_config();
        t_reject();
        t_sample();
        t_glitch(words[0], 1'b1, 1'b1);
        t_glitch(words[2], 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule : tb_top
bind cbt_top cbt_asserts i_cbt_asserts (.*);
`default_nettype wire
